// File: board_status_mode_registers.sv
// Board status flags, ID switch readback, two data-decoded command registers,
// a pulse control address and the backplane interrupt vector register.
// Assumes a local bus that presents one-cycle requests on the board clock and
// an arbiter that tells which processor owns the current access.
`timescale 1ns/1ps
`default_nettype none
`include "board_status_mode_map.svh"

module board_status_mode_registers
    import board_status_mode_pkg::*;
(
    // Clock and reset
    input  wire logic            clock,
    input  wire logic            rst_n,
    // Local bus
    input  wire bus_req_type     bus_in,
    input  wire logic            bus_cpu_y,
    output var  logic            bus_ack,
    output var  logic            bus_unmapped,
    output var  logic [15:0]     bus_rdata,
    // Board condition pins
    input  wire status_pins_type status_pins,
    input  wire logic [7:0]      id_switch_open,
    // Controlled functions
    output var  logic [7:0]      user_led_on,
    output var  first_cmd_type   first_cmd,
    output var  second_cmd_type  second_cmd,
    output var  logic            irq_reset_pulse,
    output var  logic            irq_fire_pulse,
    output var  logic            ctrl_pulse,
    output var  logic [7:0]      irq_vector
);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    localparam int ST_W = $bits(status_pins_type);

    logic [ST_W-1:0] st_sync;
    logic [7:0]      id_sync;
    status_pins_type st_s;

    input_sync #(.WIDTH(ST_W)) u_status_sync (
        .clock (clock),
        .rst_n (rst_n),
        .d     (status_pins),
        .q     (st_sync)
    );

    input_sync #(.WIDTH(8)) u_id_sync (
        .clock (clock),
        .rst_n (rst_n),
        .d     (id_switch_open),
        .q     (id_sync)
    );

    assign st_s = status_pins_type'(st_sync);

    // ****************************************************************
    // Address and data decode
    // ****************************************************************
    logic       rd_req;
    logic       wr_byte;
    logic       hit_status;
    logic       hit_id_cmd;
    logic       hit_second;
    logic       hit_vector;
    logic       hit_pulse;
    logic       code_ok;
    logic [3:0] code;
    logic       wr_first;
    logic       wr_second;
    logic       mapped;

    // Only byte writes reach the write-only registers; word writes are ignored
    assign rd_req     = bus_in.valid && !bus_in.write;
    assign wr_byte    = bus_in.valid && bus_in.write && !bus_in.word;
    assign hit_status = bus_in.addr == `ADDR_STATUS;
    assign hit_id_cmd = bus_in.addr == `ADDR_ID_FIRST_CMD;
    assign hit_second = bus_in.addr == `ADDR_SECOND_CMD;
    assign hit_vector = bus_in.addr == `ADDR_IRQ_VECTOR;
    assign hit_pulse  = bus_in.addr == `ADDR_PULSE_CTRL;
    // Values above 0F name no function and are dropped
    assign code       = bus_in.wdata[3:0];
    assign code_ok    = bus_in.wdata[7:4] == `CMD_HIGH_ZERO;
    assign wr_first   = wr_byte && hit_id_cmd && code_ok;
    assign wr_second  = wr_byte && hit_second && code_ok;
    assign mapped     = rd_req ? ((hit_status) || (hit_id_cmd && !bus_in.word))
                               : (wr_byte && (hit_id_cmd || hit_second
                                              || hit_vector || hit_pulse));

    // ****************************************************************
    // Status byte assembly
    // ****************************************************************
    logic [7:0] status_byte;

    // Halt, configuration and owner bits read zero on single-processor boards
    always_comb begin
        status_byte               = 8'h00;
        status_byte[`ST_PARITY]   = st_s.parity_error;
        status_byte[`ST_ABORT]    = !st_s.abort_req;
        status_byte[`ST_SYSFAIL]  = !st_s.sysfail_seen;
        status_byte[`ST_ACFAIL]   = !st_s.acfail_seen;
        status_byte[`ST_BLT]      = !st_s.blt_error;
        status_byte[`ST_RUNNING]  = st_s.dual_cpu && !st_s.other_cpu_halted;
        status_byte[`ST_DUAL]     = st_s.dual_cpu;
        // Owner comes straight from the arbiter, so it mirrors the reader
        status_byte[`ST_OWNER]    = st_s.dual_cpu && bus_cpu_y;
    end

    // ****************************************************************
    // Bus answer
    // ****************************************************************
    // Every request is answered one cycle later, mapped or not
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bus_ack      <= 1'b0;
            bus_unmapped <= 1'b0;
        end else begin
            bus_ack      <= bus_in.valid;
            bus_unmapped <= bus_in.valid && !mapped;
        end
    end

    // Read data: byte reads in the low lane, word read packs flags over switches
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bus_rdata <= 16'h0000;
        end else if (rd_req && hit_status && bus_in.word) begin
            bus_rdata <= {status_byte, id_sync};
        end else if (rd_req && hit_status) begin
            bus_rdata <= {8'h00, status_byte};
        end else if (rd_req && hit_id_cmd && !bus_in.word) begin
            bus_rdata <= {8'h00, id_sync};
        end else begin
            bus_rdata <= 16'h0000;
        end
    end

    // ****************************************************************
    // User LEDs
    // ****************************************************************
    // Codes 0-3 light an LED, 8-B darken it; the function codes pass by
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            user_led_on <= {`LED_RESET, `LED_RESET};
        end else begin
            if (wr_first && !code[`CMD_FUNC_BIT]) begin
                user_led_on[code[1:0]] <= !code[`CMD_OFF_BIT];
            end
            if (wr_second && !code[`CMD_FUNC_BIT]) begin
                user_led_on[{1'b1, code[1:0]}] <= !code[`CMD_OFF_BIT];
            end
        end
    end

    // ****************************************************************
    // First command register functions
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            first_cmd.sysfail_drive <= 1'b1;
            first_cmd.slave_protect <= 1'b0;
            first_cmd.parity_report <= 1'b0;
        end else if (wr_first) begin
            case (code)
                `M1_FAIL_ON:  first_cmd.sysfail_drive <= 1'b1;
                `M1_FAIL_OFF: first_cmd.sysfail_drive <= 1'b0;
                `M1_PROT_OFF: first_cmd.slave_protect <= 1'b0;
                `M1_PROT_ON:  first_cmd.slave_protect <= 1'b1;
                `M1_PAR_OFF:  first_cmd.parity_report <= 1'b0;
                `M1_PAR_ON:   first_cmd.parity_report <= 1'b1;
                default: begin
                end
            endcase
        end
    end

    // Interrupter strobes last one cycle; the interrupter keeps its own state
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irq_reset_pulse <= 1'b0;
            irq_fire_pulse  <= 1'b0;
        end else begin
            irq_reset_pulse <= wr_first && code == `M1_IRQ_RESET;
            irq_fire_pulse  <= wr_first && code == `M1_IRQ_FIRE;
        end
    end

    // ****************************************************************
    // Second command register functions
    // ****************************************************************
    // Watchdog enable uses 0C: the printed 00 would clash with LED 4
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            second_cmd <= '0;
        end else if (wr_second) begin
            case (code)
                `M2_WD_OFF:     second_cmd.watchdog_run    <= 1'b0;
                `M2_WD_ON:      second_cmd.watchdog_run    <= 1'b1;
                `M2_DSNOOP_OFF: second_cmd.daughter_snoop  <= 1'b0;
                `M2_DSNOOP_ON:  second_cmd.daughter_snoop  <= 1'b1;
                `M2_BSNOOP_OFF: second_cmd.backplane_snoop <= 1'b0;
                `M2_BSNOOP_ON:  second_cmd.backplane_snoop <= 1'b1;
                `M2_SLAVE_OFF:  second_cmd.slave_access    <= 1'b0;
                `M2_SLAVE_ON:   second_cmd.slave_access    <= 1'b1;
                default: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // Pulse control address and interrupt vector
    // ****************************************************************
    // Any byte written to the pulse address strobes, whatever its value
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_pulse <= 1'b0;
        end else begin
            ctrl_pulse <= wr_byte && hit_pulse;
        end
    end

    // Vector held for the interrupt acknowledge cycle of the processor
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irq_vector <= `VECTOR_RESET;
        end else if (wr_byte && hit_vector) begin
            irq_vector <= bus_in.wdata;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_status_byte;
        (rd_req && hit_status && !bus_in.word)
            |=> bus_ack && bus_rdata == {8'h00, $past(status_byte)};
    endproperty
    a_status_byte: assert property (p_status_byte)
        else $error("status byte read returned wrong data");

    property p_status_word;
        (rd_req && hit_status && bus_in.word)
            |=> bus_rdata[15:8] == $past(status_byte) && bus_rdata[7:0] == $past(id_sync);
    endproperty
    a_status_word: assert property (p_status_word)
        else $error("status word read lanes wrong");

    property p_single_zero;
        (rd_req && hit_status && !bus_in.word && !st_s.dual_cpu)
            |=> bus_rdata[7:5] == 3'b000;
    endproperty
    a_single_zero: assert property (p_single_zero)
        else $error("single-processor flags not zero");

    property p_owner;
        (rd_req && hit_status && !bus_in.word && st_s.dual_cpu)
            |=> bus_rdata[`ST_OWNER] == $past(bus_cpu_y);
    endproperty
    a_owner: assert property (p_owner)
        else $error("owner bit does not match accessing processor");

    property p_id_read;
        (rd_req && hit_id_cmd && !bus_in.word) |=> bus_rdata == {8'h00, $past(id_sync)};
    endproperty
    a_id_read: assert property (p_id_read)
        else $error("ID read returned wrong data");

    property p_led_first;
        (wr_first && !code[`CMD_FUNC_BIT])
            |=> user_led_on[$past(code[1:0])] == !$past(code[`CMD_OFF_BIT]);
    endproperty
    a_led_first: assert property (p_led_first)
        else $error("lower LED did not follow command");

    property p_led_second;
        (wr_second && !code[`CMD_FUNC_BIT] && !wr_first)
            |=> user_led_on[{1'b1, $past(code[1:0])}] == !$past(code[`CMD_OFF_BIT]);
    endproperty
    a_led_second: assert property (p_led_second)
        else $error("upper LED did not follow command");

    property p_fail;
        (wr_first && code == `M1_FAIL_OFF) |=> !first_cmd.sysfail_drive [*1] ##0
            $stable(user_led_on);
    endproperty
    a_fail: assert property (p_fail)
        else $error("fail drive not cleared or LEDs disturbed");

    property p_fire_cause;
        irq_fire_pulse |-> $past(wr_first) && $past(code) == `M1_IRQ_FIRE;
    endproperty
    a_fire_cause: assert property (p_fire_cause)
        else $error("interrupter fired without its command");

    property p_watchdog;
        (wr_second && code == `M2_WD_ON) ##1 (!wr_second [*2])
            |-> second_cmd.watchdog_run && $stable(second_cmd.watchdog_run);
    endproperty
    a_watchdog: assert property (p_watchdog)
        else $error("watchdog monitor not enabled by 0C");

    property p_ignore_high;
        (bus_in.valid && bus_in.write && hit_second && bus_in.wdata[7:4] != 4'h0)
            |=> $stable(second_cmd) && $stable(user_led_on) && !irq_fire_pulse;
    endproperty
    a_ignore_high: assert property (p_ignore_high)
        else $error("undefined command value changed state");

    property p_pulse;
        (wr_byte && hit_pulse) |=> ctrl_pulse ##1 ($past(wr_byte && hit_pulse) || !ctrl_pulse);
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("control pulse wrong");

    property p_vector;
        (wr_byte && hit_vector) |=> irq_vector == $past(bus_in.wdata);
    endproperty
    a_vector: assert property (p_vector)
        else $error("vector register not loaded");

    property p_reset_default;
        disable iff (1'b0)
        !rst_n |=> user_led_on == 8'hFF && first_cmd.sysfail_drive
                   && second_cmd == '0 && !first_cmd.slave_protect;
    endproperty
    a_reset_default: assert property (p_reset_default)
        else $error("functions not at default after reset");

endmodule : board_status_mode_registers

`default_nettype wire

// File: board_status_mode_map.svh
// Address map, field positions, command codes and reset values of the board
// status and command register bank.
// Assumes inclusion by bare name from the package and the register bank.
`ifndef BOARD_STATUS_MODE_MAP_SVH
`define BOARD_STATUS_MODE_MAP_SVH

// ****************************************************************
// Byte addresses on the local bus
// ****************************************************************
`define ADDR_IRQ_VECTOR     32'hFE300000
`define ADDR_STATUS         32'hFE380002
`define ADDR_ID_FIRST_CMD   32'hFE380003
`define ADDR_SECOND_CMD     32'hFE384003
`define ADDR_PULSE_CTRL     32'hFE388003

// ****************************************************************
// Status bit positions
// ****************************************************************
`define ST_PARITY           0
`define ST_ABORT            1
`define ST_SYSFAIL          2
`define ST_ACFAIL           3
`define ST_BLT              4
`define ST_RUNNING          5
`define ST_DUAL             6
`define ST_OWNER            7

// ****************************************************************
// Command code fields and values (low nibble of written byte)
// ****************************************************************
`define CMD_FUNC_BIT        2
`define CMD_OFF_BIT         3
`define CMD_HIGH_ZERO       4'h0
`define M1_FAIL_ON          4'h4
`define M1_FAIL_OFF         4'hC
`define M1_PROT_OFF         4'h5
`define M1_PROT_ON          4'hD
`define M1_PAR_OFF          4'h6
`define M1_PAR_ON           4'hE
`define M1_IRQ_RESET        4'h7
`define M1_IRQ_FIRE         4'hF
`define M2_WD_OFF           4'h4
`define M2_WD_ON            4'hC
`define M2_DSNOOP_OFF       4'h5
`define M2_DSNOOP_ON        4'hD
`define M2_BSNOOP_OFF       4'h6
`define M2_BSNOOP_ON        4'hE
`define M2_SLAVE_OFF        4'h7
`define M2_SLAVE_ON         4'hF

// ****************************************************************
// Reset values
// ****************************************************************
`define LED_RESET           4'hF
`define VECTOR_RESET        8'h0F

`endif

// File: board_status_mode_pkg.sv
// Types shared by the board status and command register bank.
// Assumes the map header is on the include path.
package board_status_mode_pkg;

    `include "board_status_mode_map.svh"

    // Local bus request, one cycle wide
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        word;
        logic [31:0] addr;
        logic [7:0]  wdata;
    } bus_req_type;

    // Board condition pins, active high meaning
    typedef struct packed {
        logic parity_error;
        logic abort_req;
        logic sysfail_seen;
        logic acfail_seen;
        logic blt_error;
        logic other_cpu_halted;
        logic dual_cpu;
    } status_pins_type;

    // Functions held by the first command register
    typedef struct packed {
        logic sysfail_drive;
        logic slave_protect;
        logic parity_report;
    } first_cmd_type;

    // Functions held by the second command register
    typedef struct packed {
        logic watchdog_run;
        logic daughter_snoop;
        logic backplane_snoop;
        logic slave_access;
    } second_cmd_type;

endpackage : board_status_mode_pkg

// File: input_sync.sv
// Two-stage synchroniser for a group of asynchronous level inputs.
// Assumes inputs are levels that change slowly against the clock.
`timescale 1ns/1ps
`default_nettype none

module input_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    // Levels
    input  wire logic [WIDTH-1:0] d,
    output var  logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule : input_sync

`default_nettype wire

// File: board_status_mode_registers_tb.sv
// Self-checking bench for the board status and command register bank.
// Assumes the package and its map header are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
`include "board_status_mode_map.svh"

module board_status_mode_registers_tb
    import board_status_mode_pkg::*;
;
    // ****************************************************************
    // Signals, model state and expectation queue
    // ****************************************************************
    typedef struct { int due; logic um; logic [15:0] rd; logic [25:0] fx; } exp_type;
    logic            clock = 1'b0;
    logic            rst_n;
    bus_req_type     bus_in;
    logic            bus_cpu_y;
    status_pins_type status_pins;
    logic [7:0]      id_switch_open;
    logic            bus_ack;
    logic            bus_unmapped;
    logic [15:0]     bus_rdata;
    logic [7:0]      user_led_on;
    first_cmd_type   first_cmd;
    second_cmd_type  second_cmd;
    logic            irq_reset_pulse;
    logic            irq_fire_pulse;
    logic            ctrl_pulse;
    logic [7:0]      irq_vector;
    logic [7:0]      led_m;
    logic [7:0]      vec_m;
    logic [2:0]      f_m;
    logic [3:0]      s_m;
    exp_type         q[$];
    int              cyc = 0;
    int              err_count = 0;
    int              n_compared = 0;
    integer          seed = 32'h831CFFC9;

    board_status_mode_registers dut (
        .clock(clock), .rst_n(rst_n), .bus_in(bus_in), .bus_cpu_y(bus_cpu_y),
        .bus_ack(bus_ack), .bus_unmapped(bus_unmapped), .bus_rdata(bus_rdata),
        .status_pins(status_pins), .id_switch_open(id_switch_open),
        .user_led_on(user_led_on), .first_cmd(first_cmd), .second_cmd(second_cmd),
        .irq_reset_pulse(irq_reset_pulse), .irq_fire_pulse(irq_fire_pulse),
        .ctrl_pulse(ctrl_pulse), .irq_vector(irq_vector)
    );

    // 100 ns board clock and a cycle count for due dates
    always #50 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;

    // ****************************************************************
    // Model, driver and compare tasks
    // ****************************************************************
    task automatic rst_model();
        led_m = 8'hFF;
        f_m = 3'h4;
        s_m = 4'h0;
        vec_m = 8'h0F;
    endtask : rst_model

    function automatic logic [7:0] st_exp(input logic y);
        status_pins_type p;
        p = status_pins;
        return {p.dual_cpu & y, p.dual_cpu, p.dual_cpu & ~p.other_cpu_halted, ~p.blt_error,
                ~p.acfail_seen, ~p.sysfail_seen, ~p.abort_req, p.parity_error};
    endfunction : st_exp

    // Bit 3 set turns a function on and darkens an LED; only fail drive is set by the low code
    task automatic cmd(input logic sec, input logic [3:0] c, output logic [2:0] pl);
        pl = 3'h0;
        if (!c[2] && sec) led_m[4 + c[1:0]] = ~c[3];
        else if (!c[2]) led_m[c[1:0]] = ~c[3];
        else if (sec) s_m[3 - c[1:0]] = c[3];
        else if (c[1:0] == 2'h0) f_m[2] = ~c[3];
        else if (c[1:0] == 2'h3) pl = c[3] ? 3'h2 : 3'h4;
        else f_m[2 - c[1:0]] = c[3];
    endtask : cmd

    // One request per falling edge; the expectation is queued with its due cycle
    task automatic req(input logic wr, input logic wd, input logic [31:0] a,
                       input logic [7:0] d);
        exp_type     e;
        logic [31:0] r;
        logic [2:0]  pl;
        @(negedge clock);
        r = $random(seed);
        pl = 3'h0;
        bus_cpu_y = r[0];
        bus_in = '{1'b1, wr, wd, a, d};
        // Request is taken at the next rising edge, which also registers its answer
        e.due = cyc + 1;
        e.um = 1'b1;
        e.rd = 16'h0000;
        if (!wr && a == `ADDR_STATUS) begin
            e.um = 1'b0;
            e.rd = wd ? {st_exp(r[0]), id_switch_open} : {8'h00, st_exp(r[0])};
        end else if (!wr && !wd && a == `ADDR_ID_FIRST_CMD) begin
            e.um = 1'b0;
            e.rd = {8'h00, id_switch_open};
        end else if (wr && !wd && (a == `ADDR_ID_FIRST_CMD || a == `ADDR_SECOND_CMD)) begin
            e.um = 1'b0;
            if (d[7:4] == 4'h0) cmd(a == `ADDR_SECOND_CMD, d[3:0], pl);
        end else if (wr && !wd && a == `ADDR_IRQ_VECTOR) begin
            e.um = 1'b0;
            vec_m = d;
        end else if (wr && !wd && a == `ADDR_PULSE_CTRL) begin
            e.um = 1'b0;
            pl = 3'h1;
        end
        e.fx = {led_m, f_m, s_m, vec_m, pl};
        q.push_back(e);
    endtask : req

    task automatic idle();
        @(negedge clock);
        bus_in.valid = 1'b0;
    endtask : idle

    task automatic cmp_rd(input logic [17:0] got, input logic [17:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t answer got %h expected %h", $time, got, exp);
        end
    endtask : cmp_rd

    task automatic cmp_fx(input logic [25:0] got, input logic [25:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t functions got %h expected %h", $time, got, exp);
        end
    endtask : cmp_fx

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    // Answer must land exactly on its due cycle; nothing may pulse in between
    always @(negedge clock) begin
        exp_type e;
        if (rst_n === 1'b1) begin
            if (q.size() > 0 && q[0].due == cyc) begin
                e = q.pop_front();
                cmp_rd({bus_ack, bus_unmapped, bus_rdata}, {1'b1, e.um, e.rd});
                cmp_fx({user_led_on, first_cmd, second_cmd, irq_vector, irq_reset_pulse,
                        irq_fire_pulse, ctrl_pulse}, e.fx);
            end else begin
                cmp_rd({bus_ack, bus_unmapped, bus_rdata}, 18'h0);
                cmp_fx({23'h0, irq_reset_pulse, irq_fire_pulse, ctrl_pulse}, 26'h0);
            end
        end
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        logic [31:0] r;
        logic [31:0] tbl [8];
        tbl = '{`ADDR_IRQ_VECTOR, `ADDR_STATUS, `ADDR_ID_FIRST_CMD, `ADDR_ID_FIRST_CMD,
                `ADDR_SECOND_CMD, `ADDR_SECOND_CMD, `ADDR_PULSE_CTRL, 32'hFE388000};
        rst_n = 1'b0;
        bus_in = '0;
        bus_cpu_y = 1'b0;
        status_pins = '0;
        id_switch_open = 8'h00;
        rst_model();
        repeat (5) @(negedge clock);
        rst_n = 1'b1;
        // Defaults, then reserved and wrong-width places
        req(1'b0, 1'b0, 32'h0, 8'h00);
        req(1'b0, 1'b0, `ADDR_IRQ_VECTOR, 8'h00);
        req(1'b1, 1'b0, `ADDR_STATUS, 8'h55);
        req(1'b1, 1'b1, `ADDR_ID_FIRST_CMD, 8'h08);
        req(1'b0, 1'b1, `ADDR_ID_FIRST_CMD, 8'h00);
        idle();
        $display("test defaults done");
        // Random pin sets; synchronisers need a few edges to settle
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            @(negedge clock);
            bus_in.valid = 1'b0;
            status_pins = r[6:0];
            id_switch_open = r[15:8];
            repeat (3) @(negedge clock);
            req(1'b0, 1'b0, `ADDR_STATUS, 8'h00);
            req(1'b0, 1'b1, `ADDR_STATUS, 8'h00);
            req(1'b0, 1'b0, `ADDR_ID_FIRST_CMD, 8'h00);
        end
        idle();
        $display("test status done");
        // Every code on both command registers, swept up from 0 to F and back down to 0
        for (int i = 0; i < 32; i++) req(1'b1, 1'b0, `ADDR_ID_FIRST_CMD, 8'((i < 16) ? i : 31 - i));
        req(1'b1, 1'b0, `ADDR_ID_FIRST_CMD, 8'h13);
        for (int i = 0; i < 32; i++) req(1'b1, 1'b0, `ADDR_SECOND_CMD, 8'((i < 16) ? i : 31 - i));
        req(1'b1, 1'b0, `ADDR_SECOND_CMD, 8'h1C);
        idle();
        $display("test commands done");
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            req(1'b1, 1'b0, `ADDR_IRQ_VECTOR, r[7:0]);
            req(1'b1, 1'b0, `ADDR_PULSE_CTRL, r[15:8]);
            req(1'b1, 1'b1, `ADDR_PULSE_CTRL, r[23:16]);
            req(1'b0, 1'b0, `ADDR_PULSE_CTRL, 8'h00);
        end
        idle();
        $display("test vector and pulse done");
        // Reset in mid-run after moving functions away from their defaults
        req(1'b1, 1'b0, `ADDR_ID_FIRST_CMD, 8'h0C);
        req(1'b1, 1'b0, `ADDR_SECOND_CMD, 8'h0F);
        req(1'b1, 1'b0, `ADDR_SECOND_CMD, 8'h0C);
        idle();
        repeat (3) @(negedge clock);
        rst_n = 1'b0;
        repeat (5) @(negedge clock);
        rst_n = 1'b1;
        rst_model();
        repeat (3) req(1'b0, 1'b0, 32'h0, 8'h00);
        $display("test second reset done");
        for (int i = 0; i < 40; i++) begin
            r = $random(seed);
            req(r[4], r[5] & r[6], tbl[r[10:8]], r[3] ? {4'h0, r[15:12]} : r[23:16]);
        end
        idle();
        repeat (4) @(negedge clock);
        $display("test random mix done");
        end_sim();
    end

    // Run needs about 210 cycles; 3000, over fourteen times that, means a hang
    initial begin
        repeat (3000) @(posedge clock);
        err_count++;
        $display("BAD t=%0t run did not finish", $time);
        end_sim();
    end
endmodule : board_status_mode_registers_tb
`default_nettype wire
